// ### src/gpc_pkg.sv
// Package for the general purpose pin block: register map, reset values, pin roles.
// Assumes a single core clock domain and a configuration-space register port.
package gpc_pkg;

   // ---------------------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------------------
   localparam int unsigned NUM_PINS        = 32;
   localparam int unsigned CFG_ADDR_W      = 12;

   // ---------------------------------------------------------------------------
   // Register offsets in the upstream port configuration space (byte addresses)
   // ---------------------------------------------------------------------------
   localparam logic [11:0] OFS_PIN_FUNCTION_SELECT  = 12'h200;
   localparam logic [11:0] OFS_PIN_DIRECTION_SELECT = 12'h204;
   localparam logic [11:0] OFS_PIN_DATA_VALUE       = 12'h208;

   // ---------------------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------------------
   localparam logic [31:0] RST_FUNCTION  = 32'h0000_0000;
   localparam logic [31:0] RST_DIRECTION = 32'h0000_0000;
   localparam logic [31:0] RST_DATA      = 32'h0000_0000;

   // ---------------------------------------------------------------------------
   // Alternate function pin positions
   // ---------------------------------------------------------------------------
   localparam int unsigned PIN_EVENT_OUT      = 5;
   localparam int unsigned PIN_PORT_RST_FIRST = 6;
   localparam int unsigned NUM_PORT_RST       = 15;
   localparam int unsigned PIN_EXP_INT_FIRST  = 21;
   localparam int unsigned NUM_EXP_INT_LOW    = 8;
   localparam int unsigned PIN_EXP_INT_HIGH   = 31;
   localparam int unsigned EXP_INT_HIGH_IDX   = 10;
   localparam int unsigned NUM_EXP_INT        = 11;

   // Mask of pins whose alternate function drives the pin.
   localparam logic [31:0] ALT_OUT_MASK  = 32'h001F_FFE0;
   // Mask of pins whose alternate function is an input.
   localparam logic [31:0] ALT_IN_MASK   = 32'h9FE0_0000;

   // ---------------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS  = 8000;
   localparam int unsigned SAMPLE_TIME_PS = 128000;
   localparam int unsigned SAMPLE_CYCLES  = (SAMPLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SAMPLE_CNT_W   = $clog2(SAMPLE_CYCLES);

   // ---------------------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------------------
   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic [CFG_ADDR_W-1:0] addr;
      logic [31:0]           wdata;
   } gpc_cfg_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } gpc_cfg_rsp_t;

   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
   } gpc_pin_drv_t;

endpackage : gpc_pkg

// ### src/gpc_pin_control.sv
// General purpose pin block: 32 pins as input, output or alternate function.
// Assumes register requests come synchronous to i_ref_clk and pins pass through pads.
//
// Overview of operation
// - Thirty-two pins, each independently an input or an output; pins 5 to 28 and 31 also have an alternate function.
// - Function bit 0 plus direction picks input/output; function 1 picks alternate.
// - After reset every pin is a general input with driver off.
// - Inputs are synchronised and sampled once per 128 ns interval.
// - In general mode the pin's alternate function is held inactive.
// - General inputs are captured into the pin data register.
// - Pin data reads return the sampled pin level in every mode.
// - General outputs drive the stored pin data bit onto the pin.
// - Pin 5 alternate function is the general event output.
// - Pins 6 to 20 alternate function are downstream port resets 1 to 15.
// - Pins 21 to 28 are expander interrupts 0 to 7, pin 31 is 10.
// - The three registers live in upstream port configuration space.
// - Alternate pins follow their function and remain readable through pin data.
module gpc_pin_control #(
   parameter int unsigned PINS = gpc_pkg::NUM_PINS
) (
   // Clock and reset
   input  wire logic                                  i_ref_clk,
   input  wire logic                                  i_rst,
   // Configuration space register port
   input  wire gpc_pkg::gpc_cfg_req_t                 i_cfg_req,
   output gpc_pkg::gpc_cfg_rsp_t                      o_cfg_rsp,
   // Pins
   input  wire logic [PINS-1:0]                       i_pin,
   output logic      [PINS-1:0]                       o_pin,
   output logic      [PINS-1:0]                       o_pin_oe,
   // Alternate function sources (active low, from on-chip logic)
   input  wire logic                                  i_general_event_out_n,
   input  wire logic [gpc_pkg::NUM_PORT_RST-1:0]      i_port_reset_out_n,
   // Alternate function sinks (active low, to expander logic)
   output logic      [gpc_pkg::NUM_EXP_INT-1:0]       o_expander_interrupt_n
);
   import gpc_pkg::*;

   if (PINS != NUM_PINS) begin : g_bad_pins
      $error("gpc_pin_control: PINS must equal 32");
   end

   // ---------------------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------------------
   function automatic logic [1:0] reg_sel(input logic [CFG_ADDR_W-1:0] a);
      unique case (a)
         OFS_PIN_FUNCTION_SELECT:  reg_sel = 2'h1;
         OFS_PIN_DIRECTION_SELECT: reg_sel = 2'h2;
         OFS_PIN_DATA_VALUE:       reg_sel = 2'h3;
         default:                  reg_sel = 2'h0;
      endcase
   endfunction : reg_sel

   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   logic [31:0]             func_r,    func_nxt;
   logic [31:0]             dir_r,     dir_nxt;
   logic [31:0]             dout_r,    dout_nxt;
   logic [31:0]             sync1_r,   sync1_nxt;
   logic [31:0]             sync2_r,   sync2_nxt;
   logic [31:0]             smp_r,     smp_nxt;
   logic [SAMPLE_CNT_W-1:0] cnt_r,     cnt_nxt;
   gpc_cfg_rsp_t            rsp_r,     rsp_nxt;
   gpc_pin_drv_t            drv_r,     drv_nxt;
   logic [NUM_EXP_INT-1:0]  xint_r,    xint_nxt;
   logic [1:0]              sel;
   logic                    tick;

   assign sel  = reg_sel(i_cfg_req.addr);
   assign tick = (cnt_r == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1));

   // ---------------------------------------------------------------------------
   // Register file and sampling
   // ---------------------------------------------------------------------------
   always_comb begin
      func_nxt  = func_r;
      dir_nxt   = dir_r;
      dout_nxt  = dout_r;
      rsp_nxt   = '0;
      sync1_nxt = i_pin;
      sync2_nxt = sync1_r;
      cnt_nxt   = tick ? '0 : cnt_r + 1'b1;
      smp_nxt   = tick ? sync2_r : smp_r;
      if (i_cfg_req.wr) begin
         unique case (sel)
            2'h1:    func_nxt = i_cfg_req.wdata;
            2'h2:    dir_nxt  = i_cfg_req.wdata;
            2'h3:    dout_nxt = i_cfg_req.wdata;
            default: ;
         endcase
      end
      if (i_cfg_req.rd || i_cfg_req.wr) begin
         rsp_nxt.valid = 1'b1;
      end
      if (i_cfg_req.rd) begin
         unique case (sel)
            2'h1:    rsp_nxt.rdata = func_r;
            2'h2:    rsp_nxt.rdata = dir_r;
            2'h3:    rsp_nxt.rdata = smp_r;
            default: rsp_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         func_r  <= RST_FUNCTION;
         dir_r   <= RST_DIRECTION;
         dout_r  <= RST_DATA;
         sync1_r <= '0;
         sync2_r <= '0;
         smp_r   <= '0;
         cnt_r   <= '0;
         rsp_r   <= '0;
      end else begin
         func_r  <= func_nxt;
         dir_r   <= dir_nxt;
         dout_r  <= dout_nxt;
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         smp_r   <= smp_nxt;
         cnt_r   <= cnt_nxt;
         rsp_r   <= rsp_nxt;
      end
   end

   // ---------------------------------------------------------------------------
   // Pin drivers, one slice per pin
   // ---------------------------------------------------------------------------
   logic [31:0] alt_src;

   always_comb begin
      alt_src                  = 32'hFFFF_FFFF;
      alt_src[PIN_EVENT_OUT]   = i_general_event_out_n;
      alt_src[PIN_PORT_RST_FIRST +: NUM_PORT_RST] = i_port_reset_out_n;
   end

   for (genvar p = 0; p < 32; p++) begin : g_pin
      always_comb begin
         if (func_r[p]) begin
            drv_nxt.out[p] = alt_src[p];
            drv_nxt.oe[p]  = ALT_OUT_MASK[p];
         end else begin
            drv_nxt.out[p] = dout_r[p];
            drv_nxt.oe[p]  = dir_r[p];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Expander interrupt inputs, inactive high unless alternate function selected
   // ---------------------------------------------------------------------------
   always_comb begin
      xint_nxt = '1;
      for (int i = 0; i < NUM_EXP_INT_LOW; i++) begin
         if (func_r[PIN_EXP_INT_FIRST + i]) begin
            xint_nxt[i] = sync2_r[PIN_EXP_INT_FIRST + i];
         end
      end
      if (func_r[PIN_EXP_INT_HIGH]) begin
         xint_nxt[EXP_INT_HIGH_IDX] = sync2_r[PIN_EXP_INT_HIGH];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         drv_r  <= '0;
         xint_r <= '1;
      end else begin
         drv_r  <= drv_nxt;
         xint_r <= xint_nxt;
      end
   end

   assign o_cfg_rsp              = rsp_r;
   assign o_pin                  = drv_r.out;
   assign o_pin_oe               = drv_r.oe;
   assign o_expander_interrupt_n = xint_r;

   // ---------------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_out_mode(int p);
      !func_r[p] && dir_r[p];
   endsequence

   chk_reset_all_input: assert property ($fell(i_rst) |-> o_pin_oe == '0 && func_r == '0)
      else $error("pins not all inputs after reset");
   chk_output_drives_data: assert property (s_out_mode(3) |=> o_pin_oe[3] && o_pin[3] == $past(dout_r[3]))
      else $error("output mode pin not driving data bit");
   chk_input_no_drive: assert property (!func_r[4] && !dir_r[4] |=> !o_pin_oe[4])
      else $error("input mode pin is driven");
   chk_no_alt_drive: assert property (func_r[0] |=> !o_pin_oe[0])
      else $error("pin without alternate function driven");
   chk_event_alt: assert property (func_r[5] |=> o_pin_oe[5] && o_pin[5] == $past(i_general_event_out_n))
      else $error("event output not routed");
   chk_port_reset_alt: assert property (func_r[20] |=> o_pin[20] == $past(i_port_reset_out_n[14]))
      else $error("last port reset not routed");
   chk_expander_idle: assert property (!func_r[31] |=> o_expander_interrupt_n[10])
      else $error("unused expander interrupt not inactive");
   chk_expander_route: assert property (func_r[21] |=> o_expander_interrupt_n[0] == $past(sync2_r[21]))
      else $error("expander interrupt not routed");
   chk_sample_period: assert property (tick |=> !tick [*8] ##1 !tick [*7] ##1 tick)
      else $error("sample interval not 16 cycles");
   chk_data_read: assert property (i_cfg_req.rd && sel == 2'h3 |=> o_cfg_rsp.valid && o_cfg_rsp.rdata == $past(smp_r))
      else $error("pin data read wrong");

   // ---------------------------------------------------------------------------
   // Register port and mode checks
   // ---------------------------------------------------------------------------
   sequence s_in_mode(int p);
      !func_r[p] && !dir_r[p];
   endsequence

   sequence s_wr_sel(logic [1:0] s);
      i_cfg_req.wr && sel == s;
   endsequence

   sequence s_rd_sel(logic [1:0] s);
      i_cfg_req.rd && !i_cfg_req.wr && sel == s;
   endsequence

   chk_func_write: assert property (s_wr_sel(2'h1) |=> func_r == $past(i_cfg_req.wdata))
      else $error("function register write lost.");
   chk_dir_write: assert property (s_wr_sel(2'h2) |=> dir_r == $past(i_cfg_req.wdata))
      else $error("direction register write lost.");
   chk_data_write: assert property (s_wr_sel(2'h3) |=> dout_r == $past(i_cfg_req.wdata))
      else $error("pin data write lost.");
   chk_func_read: assert property (s_rd_sel(2'h1) |=> o_cfg_rsp.rdata == $past(func_r))
      else $error("function register read wrong.");
   chk_dir_read: assert property (s_rd_sel(2'h2) |=> o_cfg_rsp.rdata == $past(dir_r))
      else $error("direction register read wrong.");
   chk_unmapped_read: assert property (s_rd_sel(2'h0) |=> o_cfg_rsp.rdata == '0)
      else $error("unmapped read not zero.");
   chk_unmapped_write: assert property (s_wr_sel(2'h0) |=> func_r == $past(func_r))
      else $error("unmapped write changed function register.");
   chk_unmapped_keep: assert property (s_wr_sel(2'h0) |=> dir_r == $past(dir_r))
      else $error("unmapped write changed direction register.");
   chk_rsp_valid: assert property (i_cfg_req.rd || i_cfg_req.wr |=> o_cfg_rsp.valid)
      else $error("request not answered.");
   chk_rsp_idle: assert property (!i_cfg_req.rd && !i_cfg_req.wr |=> !o_cfg_rsp.valid)
      else $error("response without request.");
   chk_write_rdata: assert property (i_cfg_req.wr && !i_cfg_req.rd |=> o_cfg_rsp.rdata == '0)
      else $error("write response carries data.");

   // ---------------------------------------------------------------------------
   // Sampling checks
   // ---------------------------------------------------------------------------
   chk_sync_chain: assert property (1'b1 |=> sync2_r == $past(sync1_r))
      else $error("synchroniser chain broken.");
   chk_sample_hold: assert property (!tick |=> smp_r == $past(smp_r))
      else $error("pin data sampled between ticks.");
   chk_sample_take: assert property (tick |=> smp_r == $past(sync2_r))
      else $error("pin data not sampled on tick.");
   chk_count_range: assert property (cnt_r < SAMPLE_CYCLES)
      else $error("sample counter out of range.");
   chk_reset_regs: assert property ($fell(i_rst) |-> dir_r == '0 && !o_cfg_rsp.valid)
      else $error("registers not cleared by reset.");
   chk_reset_expander: assert property ($fell(i_rst) |-> o_expander_interrupt_n == '1)
      else $error("expander outputs active after reset.");

   // ---------------------------------------------------------------------------
   // Pin mode checks
   // ---------------------------------------------------------------------------
   chk_input_pin10: assert property (s_in_mode(10) |=> !o_pin_oe[10])
      else $error("input mode pin 10 is driven.");
   chk_output_pin31: assert property (s_out_mode(31) |=> o_pin[31] == $past(dout_r[31]))
      else $error("output mode pin 31 not driving data bit.");
   chk_output_oe31: assert property (s_out_mode(31) |=> o_pin_oe[31])
      else $error("output mode pin 31 not enabled.");
   chk_event_general: assert property (s_out_mode(5) |=> o_pin[5] == $past(dout_r[5]))
      else $error("event function leaks onto general output.");
   chk_alt_dir_ignored: assert property (func_r[7] && !dir_r[7] |=> o_pin_oe[7])
      else $error("alternate output follows direction bit.");
   chk_port_reset_first: assert property (func_r[6] |=> o_pin[6] == $past(i_port_reset_out_n[0]))
      else $error("first port reset not routed.");
   chk_port_reset_oe: assert property (func_r[6] |=> o_pin_oe[6])
      else $error("first port reset not driven.");
   chk_alt_in_release: assert property (func_r[21] |=> !o_pin_oe[21])
      else $error("expander input pin 21 is driven.");
   chk_alt_in_high: assert property (func_r[31] |=> !o_pin_oe[31])
      else $error("expander input pin 31 is driven.");
   chk_no_alt_pin30: assert property (func_r[30] |=> !o_pin_oe[30])
      else $error("pin 30 without alternate function driven.");
   chk_no_alt_pin29: assert property (func_r[29] |=> !o_pin_oe[29])
      else $error("pin 29 without alternate function driven.");

   // ---------------------------------------------------------------------------
   // Expander interrupt checks
   // ---------------------------------------------------------------------------
   chk_expander_last: assert property (func_r[28] |=> o_expander_interrupt_n[7] == $past(sync2_r[28]))
      else $error("expander interrupt 7 not routed.");
   chk_expander_high: assert property (func_r[31] |=> o_expander_interrupt_n[10] == $past(sync2_r[31]))
      else $error("expander interrupt 10 not routed.");
   chk_expander_low_idle: assert property (!func_r[21] |=> o_expander_interrupt_n[0])
      else $error("unused expander interrupt 0 not inactive.");
   chk_expander_spare: assert property (o_expander_interrupt_n[9:8] == 2'b11)
      else $error("spare expander interrupts not inactive.");

endmodule : gpc_pin_control

// ### tb/gpc_board_model.sv
// Board model: pads resolve the device drive against external board sources.
// Assumes the bench sets the external level that stands on every pin the device releases.
module gpc_board_model (
   // Device side
   input  wire logic [31:0] i_pin_out,
   input  wire logic [31:0] i_pin_oe,
   // Board side
   input  wire logic [31:0] i_ext_level,
   output logic      [31:0] o_pad
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------------------
   // Pad resolution
   // ---------------------------------------------------------------------------
   // External sources step back from any pin that the device drives.
   assign o_pad = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule : gpc_board_model

// ### tb/testbench.sv
// Testbench for the general purpose pin block.
// Assumes the package register map and a board model that echoes driven pins.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import gpc_pkg::*;
   // ---------------------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------------------
   logic          i_ref_clk, i_rst, evt_n;
   gpc_cfg_req_t  req;
   gpc_cfg_rsp_t  rsp;
   logic [31:0]   pad, pin_o, pin_oe, ext, rd, drv;
   logic [14:0]   prst_n;
   logic [10:0]   xint_n;
   int            err_total, checked, cyc;

   gpc_pin_control gpc_pin_control_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg_req(req),
      .o_cfg_rsp(rsp), .i_pin(pad), .o_pin(pin_o), .o_pin_oe(pin_oe),
      .i_general_event_out_n(evt_n), .i_port_reset_out_n(prst_n),
      .o_expander_interrupt_n(xint_n));
   gpc_board_model gpc_board_model_i (.i_pin_out(pin_o), .i_pin_oe(pin_oe),
      .i_ext_level(ext), .o_pad(pad));
   // ---------------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic reg_op(input bit wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_ref_clk) req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
      @(posedge i_ref_clk) req <= '0;
      #1;
      check({31'h0, rsp.valid}, 32'h1, "response valid");
      rd = rsp.rdata;
   endtask : reg_op

   task automatic settle(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : settle

   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   // ---------------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------------
   task automatic t_reset;
      reg_op(0, OFS_PIN_FUNCTION_SELECT, 32'h0);
      check(rd, 32'h0, "function reset");
      reg_op(0, OFS_PIN_DIRECTION_SELECT, 32'h0);
      check(rd, 32'h0, "direction reset");
      check(pin_oe, 32'h0, "driver off after reset");
      check({21'h0, xint_n}, 32'h7FF, "expander idle after reset");
   endtask : t_reset

   task automatic t_output;
      reg_op(1, OFS_PIN_DATA_VALUE, 32'hA5C3_3C5A);
      reg_op(1, OFS_PIN_DIRECTION_SELECT, 32'hFFFF_FFFF);
      settle(1);
      check(pin_oe, 32'hFFFF_FFFF, "output enable");
      check(pin_o, 32'hA5C3_3C5A, "output value");
      settle(20);
      reg_op(0, OFS_PIN_DATA_VALUE, 32'h0);
      check(rd, 32'hA5C3_3C5A, "readback in output mode");
   endtask : t_output

   task automatic t_input;
      @(posedge i_ref_clk) ext <= 32'h1234_5678;
      reg_op(1, OFS_PIN_DIRECTION_SELECT, 32'h0);
      settle(1);
      check(pin_oe, 32'h0, "input mode releases pins");
      settle(20);
      reg_op(0, OFS_PIN_DATA_VALUE, 32'h0);
      check(rd, 32'h1234_5678, "input sampled");
      check({21'h0, xint_n}, 32'h7FF, "expander held idle");
      @(posedge i_ref_clk) ext <= 32'hEDCB_A987;
      reg_op(0, OFS_PIN_DATA_VALUE, 32'h0);
      check(rd, 32'h1234_5678, "input passes synchroniser first");
      settle(20);
      reg_op(0, OFS_PIN_DATA_VALUE, 32'h0);
      check(rd, 32'hEDCB_A987, "input resampled");
   endtask : t_input

   task automatic t_alt;
      @(posedge i_ref_clk) begin
         evt_n  <= 1'b0;
         prst_n <= 15'h2A5B;
         ext    <= 32'h8AA0_0000;
      end
      reg_op(1, OFS_PIN_FUNCTION_SELECT, 32'hFFFF_FFFF);
      settle(1);
      drv = {11'h0, prst_n, evt_n, 5'h0};
      check(pin_oe, ALT_OUT_MASK, "alternate drivers");
      check(pin_o & ALT_OUT_MASK, drv, "event and port resets");
      settle(20);
      check({21'h0, xint_n}, {21'h0, ext[31], 2'b11, ext[28:21]}, "expander inputs");
      reg_op(0, OFS_PIN_DATA_VALUE, 32'h0);
      check(rd, (ALT_OUT_MASK & drv) | (~ALT_OUT_MASK & ext), "alternate readback");
   endtask : t_alt

   task automatic t_unmapped;
      reg_op(1, 12'h20C, 32'hFFFF_FFFF);
      reg_op(0, 12'h20C, 32'h0);
      check(rd, 32'h0, "unmapped read");
      reg_op(0, OFS_PIN_FUNCTION_SELECT, 32'h0);
      check(rd, 32'hFFFF_FFFF, "function kept");
   endtask : t_unmapped
   // ---------------------------------------------------------------------------
   // Clock, timeout and main sequence
   // ---------------------------------------------------------------------------
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      i_rst = 1'b1; req = '0; ext = 32'h0; evt_n = 1'b1; prst_n = '1;
      err_total = 0; checked = 0; cyc = 0; rd = '0; drv = '0;
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_reset();
      t_output();
      t_input();
      t_alt();
      t_unmapped();
      close_out();
   end
endmodule : testbench
